// *** ecr_top.sv ***
/*
 * Error capture register bank: sticky error flags, lock on first error,
 * lost-error bits while locked, error mask and I/O timeout watchdog.
 * Assumes the error detectors are synchronous to aclk, one event per
 * cycle in which an input is high, and that software reaches the bank
 * over AXI4-Lite.
 */
`timescale 1ns/1ns
`default_nettype none

module ecr_top
    import ecr_pkg::*;
#(
    parameter int IO_TMO_CYCLES = ECR_IO_TMO_CYCLES
)(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [ECR_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [ECR_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [ECR_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [ECR_DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  ecc_single_err,
    input  wire logic                  ecc_multi_err,
    input  wire logic [1:0]            ecc_source,
    input  wire logic                  host_parity_err,
    input  wire logic                  absent_memory_err,
    input  wire logic                  bus_system_err,
    input  wire logic                  bus_data_parity_err,
    input  wire logic                  bus_address_parity_err,
    input  wire logic                  initiator_master_abort,
    input  wire logic                  initiator_target_abort,
    input  wire logic                  page_entry_invalid,
    input  wire logic                  io_busy,
    output logic                       error_valid
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [ECR_NUM_CLASS-1:0] flags;
        logic [ECR_NUM_CLASS-1:0] lost;
        logic                     valid;
        logic [ECR_NUM_CLASS-1:0] mask;
        logic [31:0]              tmo_count;
        logic                     tmo_fired;
        logic                     error_valid_out;
    } ecr_bank_state_t;

    ecr_bank_state_t          state;
    ecr_bank_state_t          next_state;
    ecr_ecc_src_t             ecc_src;
    logic                     ecc_checked;
    logic                     io_timeout_evt;
    logic [ECR_NUM_CLASS-1:0] raw_evt;
    logic [ECR_NUM_CLASS-1:0] evt;
    logic [ECR_DATA_W-1:0]    wr_bits;
    logic [ECR_DATA_W-1:0]    wr_lanes;
    logic                     wr_capture;
    logic                     wr_mask;
    logic [ECR_ADDR_W-1:0]    rd_word;
    logic [ECR_ADDR_W-1:0]    wr_word;

    ecr_reg_if regs ();

    // ************************************************************
    // Bus front end
    // ************************************************************
    ecr_axil_slave u_slave (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .regs          (regs.slave_end)
    );

    assign error_valid = state.error_valid_out;

    // ************************************************************
    // Event qualification
    // ************************************************************
    assign ecc_src = ecr_ecc_src_t'(ecc_source);
    // Host reads are checked by the processor itself, so that source
    // alone can never log an ECC error; host I/O writes are still checked.
    assign ecc_checked = (ecc_src != ECR_SRC_HOST_MEM);

    // The watchdog fires once per stuck transaction, not every cycle.
    assign io_timeout_evt = io_busy && !state.tmo_fired &&
                            (state.tmo_count ==
                             32'(IO_TMO_CYCLES - 1));

    always_comb begin
        raw_evt                 = '0;
        raw_evt[ECR_BIT_COR]    = ecc_single_err && ecc_checked;
        raw_evt[ECR_BIT_UNCOR]  = ecc_multi_err && ecc_checked;
        raw_evt[ECR_BIT_HPAR]   = host_parity_err;
        raw_evt[ECR_BIT_ABSENT] = absent_memory_err;
        raw_evt[ECR_BIT_SERR]   = bus_system_err;
        raw_evt[ECR_BIT_DPAR]   = bus_data_parity_err;
        raw_evt[ECR_BIT_APAR]   = bus_address_parity_err;
        raw_evt[ECR_BIT_MABT]   = initiator_master_abort;
        raw_evt[ECR_BIT_TABT]   = initiator_target_abort;
        raw_evt[ECR_BIT_PTE]    = page_entry_invalid;
        raw_evt[ECR_BIT_IOTMO]  = io_timeout_evt;
    end

    assign evt = raw_evt & state.mask & ECR_PRIMARY_MAP;

    // ************************************************************
    // Register decode
    // ************************************************************
    assign wr_word    = {regs.wr_addr[ECR_ADDR_W-1:2], 2'h0};
    assign rd_word    = {regs.rd_addr[ECR_ADDR_W-1:2], 2'h0};
    assign wr_lanes   = ecr_strb_mask(regs.wr_strb);
    assign wr_bits    = regs.wr_data & wr_lanes;
    assign wr_capture = regs.wr_en && (wr_word == ECR_OFS_CAPTURE);
    assign wr_mask    = regs.wr_en && (wr_word == ECR_OFS_MASK);

    always_comb begin
        regs.rd_data = '0;
        if (rd_word == ECR_OFS_CAPTURE) begin
            regs.rd_data = ECR_DATA_W'(state.flags & ECR_PRIMARY_MAP) |
                           (ECR_DATA_W'(state.lost & ECR_LOST_MAP)
                            << ECR_LOST_SHIFT);
            regs.rd_data[ECR_BIT_VALID] = state.valid;
        end else if (rd_word == ECR_OFS_MASK) begin
            regs.rd_data = ECR_DATA_W'(state.mask);
        end
    end

    // ************************************************************
    // Capture, lock and release
    // ************************************************************
    always_comb begin
        logic [ECR_NUM_CLASS-1:0] clr;
        logic [ECR_NUM_CLASS-1:0] kept;
        clr  = '0;
        kept = '0;
        next_state = state;

        if (wr_mask) begin
            // Byte lanes left out by the strobes keep their old enables.
            next_state.mask = ((state.mask &
                                ~wr_lanes[ECR_NUM_CLASS-1:0]) |
                               wr_bits[ECR_NUM_CLASS-1:0]) &
                              ECR_PRIMARY_MAP;
        end

        // Lost and valid bits are read-only; only flags take a one.
        if (wr_capture) begin
            clr = wr_bits[ECR_NUM_CLASS-1:0] & ECR_PRIMARY_MAP;
        end
        kept = state.flags & ~clr;

        if (state.valid && (kept != '0)) begin
            // Still locked: the capture stays put, new events other than
            // system error are only noted as lost.
            next_state.flags = kept;
            next_state.lost  = state.lost |
                               (evt & ECR_LOST_MAP);
        end else begin
            // Unlocked, or the last flag is cleared this cycle. An event
            // in the clearing cycle is captured afresh, so none is lost.
            next_state.flags = evt;
            next_state.lost  = '0;
            next_state.valid = (evt != '0);
        end

        // Watchdog restarts with every new transaction.
        if (!io_busy) begin
            next_state.tmo_count = '0;
            next_state.tmo_fired = 1'b0;
        end else if (io_timeout_evt) begin
            next_state.tmo_fired = 1'b1;
        end else if (!state.tmo_fired) begin
            next_state.tmo_count = state.tmo_count + 32'h1;
        end

        next_state.error_valid_out = next_state.valid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state       <= '0;
            state.flags <= ECR_FLAGS_RESET;
            state.mask  <= ECR_MASK_RESET;
        end else begin
            state <= next_state;
        end
    end

endmodule // ecr_top

`default_nettype wire

// *** ecr_pkg.sv ***
/*
 * Shared constants, field layout and helper functions of the error
 * capture register bank.
 * Assumes a 32-bit AXI4-Lite register bus and a 100 MHz system clock.
 */
`default_nettype none

package ecr_pkg;

    // ************************************************************
    // Bus geometry
    // ************************************************************
    localparam int ECR_ADDR_W = 12;
    localparam int ECR_DATA_W = 32;

    localparam logic [ECR_ADDR_W-1:0] ECR_OFS_CAPTURE = 12'h000;
    localparam logic [ECR_ADDR_W-1:0] ECR_OFS_MASK    = 12'h004;

    localparam logic [1:0] ECR_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ECR_RESP_SLVERR = 2'h2;

    // ************************************************************
    // Field layout of the capture register
    // ************************************************************
    localparam int ECR_NUM_CLASS  = 12;
    localparam int ECR_BIT_COR    = 0;
    localparam int ECR_BIT_UNCOR  = 1;
    localparam int ECR_BIT_HPAR   = 2;
    localparam int ECR_BIT_ABSENT = 3;
    localparam int ECR_BIT_SERR   = 4;
    localparam int ECR_BIT_DPAR   = 5;
    localparam int ECR_BIT_APAR   = 6;
    localparam int ECR_BIT_MABT   = 7;
    localparam int ECR_BIT_TABT   = 8;
    localparam int ECR_BIT_PTE    = 9;
    localparam int ECR_BIT_IOTMO  = 11;
    localparam int ECR_LOST_SHIFT = 16;
    localparam int ECR_BIT_VALID  = 31;

    // Classes that own a flag; bit 10 is reserved.
    localparam logic [ECR_NUM_CLASS-1:0] ECR_PRIMARY_MAP = 12'hBFF;
    // Classes that own a lost bit; system error has none.
    localparam logic [ECR_NUM_CLASS-1:0] ECR_LOST_MAP    = 12'hBEF;

    localparam logic [ECR_NUM_CLASS-1:0] ECR_FLAGS_RESET = 12'h000;
    localparam logic [ECR_NUM_CLASS-1:0] ECR_MASK_RESET  = 12'h000;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam longint ECR_CLK_HZ        = 100_000_000;
    localparam longint ECR_IO_TIMEOUT_S  = 1;
    localparam int     ECR_IO_TMO_CYCLES = int'(ECR_IO_TIMEOUT_S * ECR_CLK_HZ);

    // ************************************************************
    // Sources of an ECC check
    // ************************************************************
    typedef enum logic [1:0] {
        ECR_SRC_HOST_MEM = 2'h0,
        ECR_SRC_DMA      = 2'h1,
        ECR_SRC_SG_FILL  = 2'h2,
        ECR_SRC_HOST_IOW = 2'h3
    } ecr_ecc_src_t;

    function automatic logic [ECR_DATA_W-1:0] ecr_strb_mask(
        input logic [3:0] strb);
        ecr_strb_mask = {{8{strb[3]}}, {8{strb[2]}},
                         {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    function automatic logic ecr_is_mapped(
        input logic [ECR_ADDR_W-1:0] addr);
        logic [ECR_ADDR_W-1:0] word;
        word = {addr[ECR_ADDR_W-1:2], 2'h0};
        ecr_is_mapped = (word == ECR_OFS_CAPTURE) ||
                        (word == ECR_OFS_MASK);
    endfunction

endpackage

`default_nettype wire

// *** ecr_reg_if.sv ***
/*
 * Register access carrier between the bus slave and the register bank.
 * Assumes both ends share one clock; writes are single-cycle strobes.
 */
`timescale 1ns/1ns
`default_nettype none

interface ecr_reg_if;
    import ecr_pkg::*;

    logic                  wr_en;
    logic [ECR_ADDR_W-1:0] wr_addr;
    logic [ECR_DATA_W-1:0] wr_data;
    logic [3:0]            wr_strb;
    logic [ECR_ADDR_W-1:0] rd_addr;
    logic [ECR_DATA_W-1:0] rd_data;

    modport slave_end (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                       input  rd_data);
    modport bank_end  (input  wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                       output rd_data);
endinterface

`default_nettype wire

// *** ecr_axil_slave.sv ***
/*
 * AXI4-Lite slave front end of the error capture register bank.
 * Assumes a single clock; one write and one read outstanding at a time.
 */
`timescale 1ns/1ns
`default_nettype none

module ecr_axil_slave
    import ecr_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [ECR_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [ECR_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [ECR_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [ECR_DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    ecr_reg_if.slave_end               regs
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic                  aw_held;
        logic [ECR_ADDR_W-1:0] aw_addr;
        logic                  w_held;
        logic [ECR_DATA_W-1:0] w_data;
        logic [3:0]            w_strb;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [1:0]            rresp;
        logic [ECR_DATA_W-1:0] rdata;
    } ecr_slv_state_t;

    ecr_slv_state_t state;
    ecr_slv_state_t next_state;
    logic           do_write;

    // Address and data are held separately so either may arrive first.
    assign s_axi_awready = !state.aw_held;
    assign s_axi_wready  = !state.w_held;
    assign s_axi_arready = !state.rvalid;
    assign s_axi_bvalid  = state.bvalid;
    assign s_axi_bresp   = state.bresp;
    assign s_axi_rvalid  = state.rvalid;
    assign s_axi_rresp   = state.rresp;
    assign s_axi_rdata   = state.rdata;

    assign do_write      = state.aw_held && state.w_held && !state.bvalid;
    assign regs.wr_en    = do_write;
    assign regs.wr_addr  = state.aw_addr;
    assign regs.wr_data  = state.w_data;
    assign regs.wr_strb  = state.w_strb;
    assign regs.rd_addr  = s_axi_araddr;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_state = state;
        if (s_axi_awvalid && !state.aw_held) begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state.w_held) begin
            next_state.w_held = 1'b1;
            next_state.w_data = s_axi_wdata;
            next_state.w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            next_state.aw_held = 1'b0;
            next_state.w_held  = 1'b0;
            next_state.bvalid  = 1'b1;
            next_state.bresp   = ecr_is_mapped(state.aw_addr) ?
                                 ECR_RESP_OKAY : ECR_RESP_SLVERR;
        end
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end
        if (state.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !state.rvalid) begin
            next_state.rvalid = 1'b1;
            next_state.rdata  = regs.rd_data;
            next_state.rresp  = ecr_is_mapped(s_axi_araddr) ?
                                ECR_RESP_OKAY : ECR_RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

endmodule // ecr_axil_slave

`default_nettype wire

// *** ecr_assertions.sv ***
/* Port checker of the error capture bank.
   Assumes it is bound into ecr_top and sees only that module's ports. */
`timescale 1ns/1ns
`default_nettype none

module ecr_assertions
    import ecr_pkg::*;
#(
    parameter int IO_TMO_CYCLES = 20
)(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        ecc_single_err,
    input wire logic        ecc_multi_err,
    input wire logic [1:0]  ecc_source,
    input wire logic        host_parity_err,
    input wire logic        absent_memory_err,
    input wire logic        bus_system_err,
    input wire logic        bus_data_parity_err,
    input wire logic        bus_address_parity_err,
    input wire logic        initiator_master_abort,
    input wire logic        initiator_target_abort,
    input wire logic        page_entry_invalid,
    input wire logic        io_busy,
    input wire logic        error_valid
);
    logic rd_cap;
    logic other_ev;

    assign other_ev = host_parity_err | absent_memory_err | bus_system_err
                    | bus_data_parity_err | bus_address_parity_err
                    | initiator_master_abort | initiator_target_abort
                    | page_entry_invalid | io_busy;

    // Remembers whether the read in flight targets the capture word.
    always_ff @(posedge aclk) begin
        if (!aresetn)
            rd_cap <= 1'b0;
        else if (s_axi_arvalid && s_axi_arready)
            rd_cap <= (s_axi_araddr[11:2] == 10'h000);
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && !s_axi_bvalid;
    endsequence

    a_rd_unmapped: assert property ((ar_take ##0 s_axi_araddr[11:3] != 9'h000)
        |=> s_axi_rvalid && s_axi_rresp == ECR_RESP_SLVERR
            && s_axi_rdata == 32'h0) else $error("unmapped read answer");
    a_rd_mapped: assert property ((ar_take ##0 s_axi_araddr[11:3] == 9'h000)
        |=> s_axi_rvalid && s_axi_rresp == ECR_RESP_OKAY)
        else $error("mapped read answer");
    a_rd_reserved: assert property (
        $rose(s_axi_rvalid) && rd_cap |-> (s_axi_rdata & 32'h7410_F400) == 0
            && s_axi_rdata[31] == $past(error_valid))
        else $error("capture read reserved or valid bit");
    a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer not held");
    a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer not held");
    a_wr_answer: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    a_valid_rise: assert property (
        $rose(error_valid) |-> $past(other_ev | ecc_single_err | ecc_multi_err))
        else $error("valid set without event");
    a_valid_fall: assert property (
        $fell(error_valid) && $past(aresetn) |-> $rose(s_axi_bvalid))
        else $error("valid cleared without write");
    a_host_ecc: assert property (
        (ecc_single_err || ecc_multi_err) && ecc_source == 2'h0 && !other_ev
            && !error_valid |=> !error_valid)
        else $error("host memory ecc logged");
endmodule // ecr_assertions

bind ecr_top ecr_assertions #(.IO_TMO_CYCLES(IO_TMO_CYCLES)) u_chk (.*);

`default_nettype wire

// *** ecr_tb.sv ***
/* Self-checking bench of the error capture bank over AXI4-Lite.
   Assumes ecr_top and its checker; timeout shortened to TMO cycles. */
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import ecr_pkg::*;
    localparam int TMO = 20;
    localparam logic [11:0] CAP = ECR_OFS_CAPTURE;
    localparam logic [11:0] MSK = ECR_OFS_MASK;
    localparam logic [31:0] V = 32'h8000_0000;
    logic        aclk, aresetn, error_valid;
    logic [11:0] s_axi_awaddr, s_axi_araddr, ev;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, ecc_source, resp_q;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    wire logic   ecc_single_err = ev[0], ecc_multi_err = ev[1];
    wire logic   host_parity_err = ev[2], absent_memory_err = ev[3];
    wire logic   bus_system_err = ev[4], bus_data_parity_err = ev[5];
    wire logic   bus_address_parity_err = ev[6];
    wire logic   initiator_master_abort = ev[7];
    wire logic   initiator_target_abort = ev[8];
    wire logic   page_entry_invalid = ev[9], io_busy = ev[11];
    int          err_count = 0, cmp_count = 0, cyc = 0;

    ecr_top #(.IO_TMO_CYCLES(TMO)) u_dut (.*);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ********************************************************
    // Bus cycles and comparisons
    // ********************************************************
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_rsp(input string n, input logic [1:0] e, g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    // Ready is raised only after valid shows, so every answer stalls once.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) break;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end
        s_axi_bready <= 1'b0;
        resp_q = s_axi_bresp;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) break;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        s_axi_rready <= 1'b0;
        rd_q = s_axi_rdata;
        resp_q = s_axi_rresp;
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] e,
                      input logic [1:0] r = ECR_RESP_OKAY);
        rd(a);
        chk("read data", e, rd_q);
        chk_rsp("read response", r, resp_q);
    endtask

    task automatic wc(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] r = ECR_RESP_OKAY);
        wr(a, d);
        chk_rsp("write response", r, resp_q);
    endtask

    // The I/O class is a level held past the shortened timeout.
    task automatic fire(input int i);
        @(posedge aclk);
        ev <= 12'h001 << i;
        repeat (i == 11 ? TMO + 2 : 1) @(posedge aclk);
        ev <= 12'h000;
        repeat (2) @(posedge aclk);
    endtask

    // ********************************************************
    // Scenarios
    // ********************************************************
    task automatic t_reset;
        rc(CAP, 32'h0);
        rc(MSK, 32'h0);
        rc(12'h008, 32'h0, ECR_RESP_SLVERR);
        wc(12'h008, 32'hFFFF_FFFF, ECR_RESP_SLVERR);
    endtask

    task automatic t_mask;
        wc(MSK, 32'hFFFF_FFFF);
        rc(MSK, 32'h0000_0BFF);
        s_axi_wstrb <= 4'h1;
        wc(MSK, 32'h0);
        s_axi_wstrb <= 4'hF;
        rc(MSK, 32'h0000_0B00);
        wc(MSK, 32'hFFFF_FFFF);
        wc(CAP, 32'hFFFF_FFFF);
        rc(CAP, 32'h0);
    endtask

    task automatic t_ecc_src;
        for (int s = 0; s < 4; s++) begin
            ecc_source <= 2'(s);
            fire(0);
            rc(CAP, s == 0 ? 32'h0 : V | 32'h1);
            wc(CAP, 32'h1);
        end
    endtask

    task automatic t_classes;
        logic [31:0] f;
        logic [31:0] l;
        for (int i = 0; i < 12; i++) begin
            if (i != 10) begin
                f = 32'h1 << i;
                l = (i == 4) ? 32'h0 : 32'h1 << (i + 16);
                fire(i);
                rc(CAP, f | V);
                fire(i);
                rd(CAP);
                chk("locked", f | l | V, rd_q);
                wc(CAP, f);
                rc(CAP, 32'h0);
            end
        end
    endtask

    task automatic t_lock;
        fire(5);
        fire(7);
        rc(CAP, 32'h8080_0020);
        wc(CAP, 32'h20);
        rc(CAP, 32'h0);
        wc(MSK, 32'h0000_0B7F);
        fire(7);
        rc(CAP, 32'h0);
        @(posedge aclk);
        ev <= 12'h800;
        repeat (TMO - 1) @(posedge aclk);
        ev <= 12'h000;
        rc(CAP, 32'h0);
        @(posedge aclk);
        ev <= 12'h800;
        repeat (TMO) @(posedge aclk);
        ev <= 12'h000;
        rc(CAP, V | 32'h800);
        chk("error valid", 32'h1, 32'(error_valid));
        wc(CAP, 32'h800);
        chk("error valid", 32'h0, 32'(error_valid));
    endtask

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 8000) begin
            err_count++;
            complete_run;
        end
    end

    initial begin
        aresetn = 1'b0;
        ev = 12'h000;
        ecc_source = 2'h1;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_mask;
        t_ecc_src;
        t_classes;
        t_lock;
        complete_run;
    end
endmodule // testbench

`default_nettype wire
